/* hdl/timer_channel_capture_compare.sv */
// two channels of input capture, output compare and pwm of a 16-bit timer
// assumes counter value and overflow pulse from the counter section on CLK_I
//
// Summary of operation
// - capture mode: flag sets on the selected active pin edge
// - compare mode: flag sets when counter equals channel value
// - flag clears by reading control with flag set, then writing 0
// - an event between that read and write keeps the flag set
// - writing 1 to flag does nothing; reset zeroes all control bits
// - interrupt request while flag and interrupt enable are both set
// - channel 0 buffered select disables channel 1 and frees its pin
// - nonzero edge/level: mode bit A picks compare (1) or capture (0)
// - edge/level 00: mode bit A picks preset level, 1 low, 0 high
// - edge/level 00 leaves the pin to the port
// - capture trigger: 01 rising, 10 falling, 11 both edges
// - compare action: 01 toggle, 10 clear, 11 set
// - channel 0 mode bit B set enables buffered compare/pwm regardless of bit A
// - toggle-on-overflow toggles the compare pin at each overflow
// - overflow action wins over a coincident compare action
// - max duty with toggle-on-overflow forces 100 percent duty
// - max duty change acts from the next pwm period only
// - value holds capture or compare value; reset zeroes it
// - capture: reading high byte blocks captures until low byte read
// - compare: writing high byte blocks compares until low byte write
// - overflow pulse marks counter reaching modulo, restart from zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module timer_channel_capture_compare
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   // register port
   input  wire bus_req_s    BUS_I,
   output logic [7:0]       RDATA_O,
   // counter section
   input  wire logic [15:0] CNT_I,
   input  wire logic        OVF_I,
   // channel pins
   input  wire logic [1:0]  CH_PIN_I,
   output logic [1:0]       CH_PIN_O,
   output logic [1:0]       CH_PIN_OE_N_O,
   // interrupt requests
   output logic [1:0]       IRQ_O
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // byte address of a channel's register
   function automatic logic [7:0] reg_addr(input int i,
                                           input logic [7:0] ofs);
      logic [7:0] b;
      b = (i == 0) ? `CH0_BASE : `CH1_BASE;
      return b + ofs;
   endfunction

   // operating mode from the control bits
   function automatic mode_e chan_mode(input chan_s c, input logic off);
      mode_e m;
      m = MODE_OFF;
      if (off || c.els == `ELS_OFF) begin
         m = MODE_OFF;
      end else if (c.msb) begin
         m = MODE_BUFFERED;
      end else if (c.msa) begin
         m = MODE_COMPARE;
      end else begin
         m = MODE_CAPTURE;
      end
      return m;
   endfunction

   // control/status byte as read
   function automatic logic [7:0] ctl_byte(input chan_s c);
      logic [7:0] r;
      r = `CTL_RST;
      r[`B_FLAG] = c.flag;
      r[`B_IE]   = c.ie;
      r[`B_MSB]  = c.msb;
      r[`B_MSA]  = c.msa;
      r[`B_ELSB] = c.els[1];
      r[`B_ELSA] = c.els[0];
      r[`B_TOV]  = c.tov;
      r[`B_MAX]  = c.max;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   state_s      q;
   state_s      d;
   logic [1:0]  ev;
   mode_e [1:0] mode;

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic        off;
      logic        rise;
      logic        fall;
      logic        hit;
      logic        cap_ev;
      logic        cmp_ev;
      logic [15:0] cmpv;
      logic [7:0]  w;
      logic [7:0]  rd_d;
      off    = 1'b0;
      rise   = 1'b0;
      fall   = 1'b0;
      hit    = 1'b0;
      cap_ev = 1'b0;
      cmp_ev = 1'b0;
      cmpv   = 16'h0000;
      w      = BUS_I.wdata;
      rd_d   = `RD_IDLE;
      d      = q;
      ev     = 2'h0;
      mode   = '{MODE_OFF, MODE_OFF};
      // pin synchroniser and edge history
      d.sync1 = CH_PIN_I;
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      for (int i = 0; i < 2; i++) begin
         // channel 1 is switched off by buffered mode
         off = (i == 1) && q.ch[0].msb;
         mode[i] = chan_mode(q.ch[i], off);
         rise = q.sync2[i] & ~q.prev[i];
         fall = ~q.sync2[i] & q.prev[i];
         // buffered compare uses the value pair whose low byte was last written, taken at overflow
         if (i == 0 && q.ch[0].msb) begin
            cmpv = q.sel ? q.ch[1].val : q.ch[0].val;
         end else begin
            cmpv = q.ch[i].val;
         end
         hit = (CNT_I == cmpv);
         d.ch[i].mprev = hit;
         // capture trigger decode
         cap_ev = 1'b0;
         if (mode[i] == MODE_CAPTURE && !q.ch[i].cap_lock) begin
            case (q.ch[i].els)
               `ELS_ONE:  cap_ev = rise;
               `ELS_TWO:  cap_ev = fall;
               `ELS_BOTH: cap_ev = rise | fall;
               default:   cap_ev = 1'b0;
            endcase
         end
         // compare fires once per match, not while it lasts
         cmp_ev = (mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED)
                  && hit && !q.ch[i].mprev
                  && !q.ch[i].cmp_lock;
         ev[i] = cap_ev | cmp_ev;
         // max duty sampled at period boundary
         if (OVF_I) begin
            d.ch[i].max_eff = q.ch[i].max;
         end
         // pin level
         if (mode[i] == MODE_OFF) begin
            d.ch[i].out = ~q.ch[i].msa;
         end else if (mode[i] != MODE_CAPTURE) begin
            if (q.ch[i].max_eff && q.ch[i].tov) begin
               d.ch[i].out = 1'b1;
            end else if (OVF_I && q.ch[i].tov) begin
               d.ch[i].out = ~q.ch[i].out;
            end else if (cmp_ev) begin
               case (q.ch[i].els)
                  `ELS_ONE:  d.ch[i].out = ~q.ch[i].out;
                  `ELS_TWO:  d.ch[i].out = 1'b0;
                  `ELS_BOTH: d.ch[i].out = 1'b1;
                  default:   d.ch[i].out = q.ch[i].out;
               endcase
            end
         end
         // control/status read arms the flag clear
         if (BUS_I.rd && BUS_I.addr == reg_addr(i, `OFS_CTL)) begin
            if (!off) begin
               rd_d = ctl_byte(q.ch[i]);
               d.ch[i].armed = q.ch[i].flag;
            end
         end
         // value high byte read locks captures
         if (BUS_I.rd && BUS_I.addr == reg_addr(i, `OFS_VH)) begin
            rd_d = q.ch[i].val[15:8];
            if (mode[i] == MODE_CAPTURE) begin
               d.ch[i].cap_lock = 1'b1;
            end
         end
         // value low byte read releases it
         if (BUS_I.rd && BUS_I.addr == reg_addr(i, `OFS_VL)) begin
            rd_d = q.ch[i].val[7:0];
            d.ch[i].cap_lock = 1'b0;
         end
         // control/status write
         if (BUS_I.wr && BUS_I.addr == reg_addr(i, `OFS_CTL) && !off) begin
            d.ch[i].ie  = w[`B_IE];
            d.ch[i].msb = (i == 0) ? w[`B_MSB] : 1'b0;
            d.ch[i].msa = w[`B_MSA];
            d.ch[i].els = {w[`B_ELSB], w[`B_ELSA]};
            d.ch[i].tov = w[`B_TOV];
            d.ch[i].max = w[`B_MAX];
            // zero clears only after the arming read
            if (!w[`B_FLAG] && q.ch[i].armed) begin
               d.ch[i].flag = 1'b0;
            end
            d.ch[i].armed = 1'b0;
         end
         // value high byte write locks compares
         if (BUS_I.wr && BUS_I.addr == reg_addr(i, `OFS_VH)) begin
            d.ch[i].val[15:8] = w;
            if (mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED) begin
               d.ch[i].cmp_lock = 1'b1;
            end
         end
         // value low byte write releases it and queues buffer
         if (BUS_I.wr && BUS_I.addr == reg_addr(i, `OFS_VL)) begin
            d.ch[i].val[7:0] = w;
            d.ch[i].cmp_lock = 1'b0;
            d.pend = 1'(i);
         end
         // capture latches the counter
         if (cap_ev) begin
            d.ch[i].val = CNT_I;
         end
         // event set wins over clear and disarms
         if (ev[i]) begin
            d.ch[i].flag  = 1'b1;
            d.ch[i].armed = 1'b0;
         end
      end
      // buffered register swap at the period boundary
      if (OVF_I) begin
         d.sel = q.pend;
      end
      d.rdata = rd_d;
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   // zero reset for control, value and pin state
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // pin drive only in compare modes
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         CH_PIN_O[i]      = q.ch[i].out;
         CH_PIN_OE_N_O[i] = !(mode[i] == MODE_COMPARE
                              || mode[i] == MODE_BUFFERED);
         IRQ_O[i]         = q.ch[i].flag & q.ch[i].ie;
      end
   end

   assign RDATA_O = q.rdata;

   ////////////////////////////////////////////////////////////////////
   // checks

   logic wr_ctl0;
   logic rd_ctl0;

   // control 0 access decode for checks
   assign wr_ctl0 = BUS_I.wr && BUS_I.addr == `CH0_BASE;
   assign rd_ctl0 = BUS_I.rd && BUS_I.addr == `CH0_BASE;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   // request rises only after an event or an enable write
   property p_irq_needs_flag;
      $rose(IRQ_O[0]) |-> q.ch[0].flag && q.ch[0].ie
         && ($past(ev[0]) || $past(wr_ctl0));
   endproperty
   a_irq_needs_flag: assert property (p_irq_needs_flag)
      else $error("interrupt without flag and enable");

   // capture checks watch channel 1, the channel the bench captures on
   property p_rise_capture;
      mode[1] == MODE_CAPTURE && q.ch[1].els == `ELS_ONE
      && !q.ch[1].cap_lock && q.sync2[1] && !q.prev[1]
      |=> q.ch[1].flag && q.ch[1].val == $past(CNT_I);
   endproperty
   a_rise_capture: assert property (p_rise_capture)
      else $error("rising edge did not capture");

   property p_fall_only;
      mode[1] == MODE_CAPTURE && q.ch[1].els == `ELS_TWO
      && q.sync2[1] && !q.prev[1] |-> !ev[1];
   endproperty
   a_fall_only: assert property (p_fall_only)
      else $error("falling-only capture took rising edge");

   property p_flag_fall_cause;
      $fell(q.ch[0].flag) |-> $past(wr_ctl0) && !$past(BUS_I.wdata[`B_FLAG]);
   endproperty
   a_flag_fall_cause: assert property (p_flag_fall_cause)
      else $error("flag cleared without zero write");

   property p_clear_needs_read;
      wr_ctl0 && !q.ch[0].armed && q.ch[0].flag |=> q.ch[0].flag;
   endproperty
   a_clear_needs_read: assert property (p_clear_needs_read)
      else $error("flag cleared without arming read");

   property p_arm_on_read;
      rd_ctl0 && !BUS_I.wr && q.ch[0].flag && !ev[0] |=> q.ch[0].armed;
   endproperty
   a_arm_on_read: assert property (p_arm_on_read)
      else $error("control read with flag set did not arm clear");

   property p_event_wins;
      (wr_ctl0 || q.ch[0].armed) && ev[0]
      |=> q.ch[0].flag && !q.ch[0].armed;
   endproperty
   a_event_wins: assert property (p_event_wins)
      else $error("event lost under clear");

   property p_one_no_set;
      wr_ctl0 && !q.ch[0].flag && !ev[0] |=> !q.ch[0].flag;
   endproperty
   a_one_no_set: assert property (p_one_no_set)
      else $error("write set the flag");

   property p_port_owns_pin;
      q.ch[1].els == `ELS_OFF || q.ch[0].msb |-> CH_PIN_OE_N_O[1];
   endproperty
   a_port_owns_pin: assert property (p_port_owns_pin)
      else $error("disconnected channel drives pin");

   property p_cap_lock_hold;
      q.ch[1].cap_lock && !BUS_I.wr ##1 q.ch[1].cap_lock
      |-> $stable(q.ch[1].val);
   endproperty
   a_cap_lock_hold: assert property (p_cap_lock_hold)
      else $error("capture while high byte locked");

   property p_cmp_lock;
      q.ch[0].cmp_lock |-> !ev[0];
   endproperty
   a_cmp_lock: assert property (p_cmp_lock)
      else $error("compare while high byte written alone");

   property p_ovf_wins;
      mode[0] == MODE_COMPARE && q.ch[0].tov && !q.ch[0].max_eff && OVF_I
      |=> CH_PIN_O[0] == !$past(CH_PIN_O[0]);
   endproperty
   a_ovf_wins: assert property (p_ovf_wins)
      else $error("overflow did not toggle pin");

   property p_full_duty;
      mode[0] == MODE_COMPARE && q.ch[0].tov && q.ch[0].max_eff
      |=> CH_PIN_O[0];
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("max duty not high");

   property p_max_latency;
      !OVF_I |=> q.ch[0].max_eff == $past(q.ch[0].max_eff);
   endproperty
   a_max_latency: assert property (p_max_latency)
      else $error("max duty changed mid period");

   property p_preset_level;
      q.ch[0].els == `ELS_OFF && q.ch[0].msa ##1 q.ch[0].els == `ELS_OFF
      |-> !CH_PIN_O[0];
   endproperty
   a_preset_level: assert property (p_preset_level)
      else $error("preset level not low");

endmodule

`default_nettype wire

/* pkg/tcc_consts.svh */
// constants of the two-channel capture/compare block
// assumes an 8-bit register port and 8-bit register bytes
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register byte addresses
`define CH0_BASE   8'h13
`define CH1_BASE   8'h16
`define OFS_CTL    8'h00
`define OFS_VH     8'h01
`define OFS_VL     8'h02

// control/status field positions
`define B_FLAG     7
`define B_IE       6
`define B_MSB      5
`define B_MSA      4
`define B_ELSB     3
`define B_ELSA     2
`define B_TOV      1
`define B_MAX      0

// reset values
`define CTL_RST    8'h00
`define RD_IDLE    8'h00

// edge/level codes
`define ELS_OFF    2'h0
`define ELS_ONE    2'h1
`define ELS_TWO    2'h2
`define ELS_BOTH   2'h3

`endif

/* pkg/tcc_pkg.sv */
// types of the two-channel capture/compare block
// assumes tcc_consts.svh for all numbers
package tcc_pkg;

   // channel operating mode
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_BUFFERED
   } mode_e;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;

   // per channel state
   typedef struct packed {
      logic        flag;
      logic        ie;
      logic        msb;
      logic        msa;
      logic [1:0]  els;
      logic        tov;
      logic        max;
      logic        max_eff;
      logic        out;
      logic        armed;
      logic        cap_lock;
      logic        cmp_lock;
      logic        mprev;
      logic [15:0] val;
   } chan_s;

   // whole block state
   typedef struct packed {
      chan_s [1:0] ch;
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [1:0]  prev;
      logic        sel;
      logic        pend;
      logic [7:0]  rdata;
   } state_s;

endpackage

/* tb/tb.sv */
// self-checking bench of the two-channel capture/compare block
// assumes the design package, the constants header and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tb
   import tcc_pkg::*;
;
   localparam logic [7:0] C0 = `CH0_BASE;
   localparam logic [7:0] H0 = `CH0_BASE + `OFS_VH;
   localparam logic [7:0] L0 = `CH0_BASE + `OFS_VL;
   localparam logic [7:0] C1 = `CH1_BASE;
   localparam logic [7:0] H1 = `CH1_BASE + `OFS_VH;
   localparam logic [7:0] L1 = `CH1_BASE + `OFS_VL;

   logic        clk;
   logic        rst;
   bus_req_s    bus;
   logic [7:0]  rdata;
   logic [15:0] cnt;
   logic        ovf;
   logic [1:0]  pin_i;
   logic [1:0]  pin_o;
   logic [1:0]  oe_n;
   logic [1:0]  irq;
   int          error_cnt;
   int          num_checks;
   logic [7:0]  ctl_m [2];
   logic [7:0]  v;
   logic [7:0]  vh;
   logic [15:0] val;
   logic [15:0] nv;
   logic        ep;

   timer_channel_capture_compare u_dut (
      .CLK_I         (clk),
      .RST_I         (rst),
      .BUS_I         (bus),
      .RDATA_O       (rdata),
      .CNT_I         (cnt),
      .OVF_I         (ovf),
      .CH_PIN_I      (pin_i),
      .CH_PIN_O      (pin_o),
      .CH_PIN_OE_N_O (oe_n),
      .IRQ_O         (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // one write cycle, control model follows
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      @(negedge clk);
      if (a == C0) ctl_m[0] = {ctl_m[0][7], d[6:0]};
      if (a == C1 && !ctl_m[0][`B_MSB]) ctl_m[1] = {ctl_m[1][7], d[6], 1'b0, d[4:0]};
   endtask

   // one read cycle, data taken in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   task automatic rctl(input int ch);
      rd(ch ? C1 : C0);
      chk("ctl", (ch == 1 && ctl_m[0][`B_MSB]) ? 16'h0000 : {8'h00, ctl_m[ch]}, {8'h00, v});
   endtask

   // read with flag set, then write flag zero
   task automatic clr(input int ch);
      rd(ch ? C1 : C0);
      wr(ch ? C1 : C0, ctl_m[ch] & 8'h7F);
      ctl_m[ch][7] = 1'b0;
   endtask

   // counter moves onto the value, rising edge of equality
   task automatic hit(input logic [15:0] x);
      @(posedge clk);
      cnt <= x + 16'h0001;
      @(posedge clk);
      cnt <= x;
      step(3);
   endtask

   task automatic pulse();
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      step(2);
   endtask

   task automatic edg(input logic l);
      @(posedge clk);
      pin_i[1] <= l;
      step(8);
   endtask

   // flag expectation, then value readback and clear on a capture
   task automatic cap(input logic e);
      chk("irq1", {15'h0000, e}, {15'h0000, irq[1]});
      if (e) begin
         rd(H1);
         vh = v;
         rd(L1);
         chk("capval", nv, {vh, v});
         clr(1);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #200000;
      error_cnt++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////
   // tests
   initial begin
      rst = 1'b1;
      bus = '0;
      cnt = 16'h0000;
      ovf = 1'b0;
      pin_i = 2'b00;
      error_cnt = 0;
      num_checks = 0;
      ctl_m[0] = 8'h00;
      ctl_m[1] = 8'h00;
      void'($urandom(26257));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      step(2);
      rctl(0);
      rctl(1);
      chk("irq", 16'h0000, {14'h0000, irq});
      chk("oe_n", 16'h0003, {14'h0000, oe_n});
      chk("preset hi", 16'h0003, {14'h0000, pin_o});
      rd(8'h20);
      chk("unmapped", 16'h0000, {8'h00, v});
      v = 8'($urandom) & 8'h43;
      wr(C1, v | 8'h80);
      rctl(1);
      wr(C1, 8'h00);
      wr(C0, 8'h10);
      step(2);
      chk("preset lo", 16'h0000, {15'h0000, pin_o[0]});
      chk("oe_n0", 16'h0001, {15'h0000, oe_n[0]});
      $display("test reset and preset done");
      val = 16'($urandom);
      wr(H0, val[15:8]);
      wr(L0, val[7:0]);
      wr(C0, 8'h14);
      hit(val);
      ctl_m[0][7] = 1'b1;
      ep = 1'b1;
      chk("irq masked", 16'h0000, {15'h0000, irq[0]});
      rctl(0);
      chk("oe_n cmp", 16'h0000, {15'h0000, oe_n[0]});
      clr(0);
      for (int c = 1; c < 4; c++) begin
         wr(C0, 8'h50 | 8'(c << 2));
         hit(val);
         ep = (c == 1) ? ~ep : (c == 3);
         chk("pin0 act", {15'h0000, ep}, {15'h0000, pin_o[0]});
      end
      ctl_m[0][7] = 1'b1;
      chk("irq on", 16'h0001, {15'h0000, irq[0]});
      clr(0);
      chk("cleared", 16'h0000, {15'h0000, irq[0]});
      hit(val);
      rd(C0);
      hit(val);
      wr(C0, ctl_m[0] & 8'h7F);
      chk("kept", 16'h0001, {15'h0000, irq[0]});
      clr(0);
      $display("test compare done");
      nv = 16'($urandom);
      wr(H0, nv[15:8]);
      hit({nv[15:8], val[7:0]});
      chk("cmp lock", 16'h0000, {15'h0000, irq[0]});
      wr(L0, nv[7:0]);
      hit(nv);
      chk("cmp unlock", 16'h0001, {15'h0000, irq[0]});
      wr(C0, 8'h5A);
      hit(nv);
      chk("clr act", 16'h0000, {15'h0000, pin_o[0]});
      @(posedge clk);
      cnt <= nv + 16'h0001;
      @(posedge clk);
      cnt <= nv;
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      step(2);
      chk("ovf wins", 16'h0001, {15'h0000, pin_o[0]});
      pulse();
      chk("ovf tog", 16'h0000, {15'h0000, pin_o[0]});
      wr(C0, 8'h5B);
      chk("max wait", 16'h0000, {15'h0000, pin_o[0]});
      pulse();
      hit(nv);
      chk("max on", 16'h0001, {15'h0000, pin_o[0]});
      pulse();
      chk("max hold", 16'h0001, {15'h0000, pin_o[0]});
      wr(C0, 8'h5A);
      pulse();
      hit(nv);
      chk("max off", 16'h0000, {15'h0000, pin_o[0]});
      ctl_m[0][7] = 1'b1;
      clr(0);
      $display("test overflow and max duty done");
      wr(C0, 8'h24);
      wr(C1, 8'h54);
      rctl(1);
      chk("oe_n buf", 16'h0002, {14'h0000, oe_n});
      hit(nv);
      chk("buf act", 16'h0001, {15'h0000, pin_o[0]});
      wr(C0, 8'h00);
      rctl(1);
      $display("test buffered done");
      for (int c = 1; c < 4; c++) begin
         wr(C1, 8'h40 | 8'(c << 2));
         step(2);
         nv = 16'($urandom);
         @(posedge clk);
         cnt <= nv;
         edg(1'b1);
         cap(c != 2);
         edg(1'b0);
         cap(c != 1);
      end
      nv = 16'($urandom);
      @(posedge clk);
      cnt <= nv;
      rd(H1);
      edg(1'b1);
      cap(1'b0);
      rd(L1);
      edg(1'b0);
      cap(1'b1);
      $display("test capture done");
      results();
   end
endmodule
`default_nettype wire
